// ---- bench/mfp_access_check_tb.sv ----
`timescale 1ns/10ps
module mfp_access_check_tb
    import mfp_pkg::*;
;
    logic sys_clk = 0, rst_n = 0, cp_wr = 0, cp_rd = 0, acc_valid = 0;
    logic acc_write = 0, acc_user = 0, acc_byte = 0, acc_instr = 0;
    logic bus_err_valid = 0, bus_err_linefetch = 0, bus_err_page = 0;
    logic l1_err = 0, l2_err = 0;
    logic [3:0] cp_sel = 0, bus_err_domain = 0, dom = 0;
    logic [31:0] cp_wdata = 0, acc_vaddr = 0, bus_err_addr = 0, line_start_addr = 0;
    logic [31:0] cp_rdata, mem_addr, l1_desc, l2_desc, got, va, dacr;
    logic mem_req, mem_cacheable, mem_bufferable, data_abort, prefetch_abort_tag;
    logic [1:0] l2_type = L2_SMALL, cb = 0, dv, ap;
    logic [19:0] ppn = 0;
    logic [7:0] qperm = 0;
    logic [3:0] code;
    int miscompares = 0;
    int num_checks = 0;
    logic [31:0] rv;

    // ------------------------------------------------------------
    // Clock, design and table model
    // ------------------------------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    mfp_access_check DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cp_wr(cp_wr),
        .cp_rd(cp_rd), .cp_sel(cp_sel), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
        .acc_valid(acc_valid), .acc_vaddr(acc_vaddr), .acc_write(acc_write),
        .acc_user(acc_user), .acc_byte(acc_byte), .acc_instr(acc_instr),
        .l1_desc(l1_desc), .l1_bus_err(l1_err), .l2_desc(l2_desc), .l2_bus_err(l2_err),
        .bus_err_valid(bus_err_valid), .bus_err_linefetch(bus_err_linefetch),
        .bus_err_page(bus_err_page), .bus_err_domain(bus_err_domain),
        .bus_err_addr(bus_err_addr), .line_start_addr(line_start_addr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_cacheable(mem_cacheable),
        .mem_bufferable(mem_bufferable), .data_abort(data_abort),
        .prefetch_abort_tag(prefetch_abort_tag));
    mfp_table_model tables (.dom(dom), .l2_type(l2_type), .ppn(ppn), .qperm(qperm),
        .cb(cb), .l1_desc(l1_desc), .l2_desc(l2_desc));

    // ------------------------------------------------------------
    // Shared tasks and expectations
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic wr(input logic [3:0] sel, input logic [31:0] d);
        @(negedge sys_clk) {cp_wr, cp_sel, cp_wdata} = {1'b1, sel, d};
        @(negedge sys_clk) cp_wr = 0;
    endtask : wr
    // Strobe lasts one edge; data is read a cycle after it settles
    task automatic rd(input logic [3:0] sel, output logic [31:0] d);
        @(negedge sys_clk) {cp_rd, cp_sel} = {1'b1, sel};
        @(negedge sys_clk) cp_rd = 0;
        @(negedge sys_clk) d = cp_rdata;
    endtask : rd
    task automatic acc(input logic [31:0] a, input logic w, u, b, i);
        @(negedge sys_clk) {acc_valid, acc_vaddr, acc_write, acc_user} = {1'b1, a, w, u};
        {acc_byte, acc_instr} = {b, i};
        @(negedge sys_clk) acc_valid = 0;
    endtask : acc
    // Protect bits only matter for code 00; both set is denied
    function automatic logic perm_ok(input logic [1:0] p, input logic s, r, u, w);
        case (p)
            PERM_PROT: return (s & !r) ? (!u & !w) : (!s & r & !w);
            PERM_SUP: return !u;
            PERM_UREAD: return !(u & w);
            default: return 1'b1;
        endcase
    endfunction : perm_ok
    task automatic abort_is(input logic [31:0] st, input logic [31:0] fa);
        chk(32'({mem_req, data_abort}), 32'h1);
        rd(CP_STATUS, got);
        chk(got, st);
        rd(CP_FADDR, got);
        chk(got, fa);
    endtask : abort_is

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rv = $urandom(32'h18592f20);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk) rst_n = 1;
        rd(CP_STATUS, got);
        chk(got, ZERO_WORD);
        rd(4'h0, got);
        chk(got, ZERO_WORD);
        // Random client, manager and no-access cases on small pages
        for (int n = 0; n < 60; n++) begin
            rv = $urandom;
            dacr = $urandom;
            wr(CP_CTRL, {22'h0, rv[1:0], 6'h0, 1'b0, 1'b1});
            wr(CP_DOMAIN, dacr);
            rd(CP_DOMAIN, got);
            chk(got, dacr);
            {dom, qperm, cb} = rv[15:2];
            ppn = 20'($urandom);
            va = $urandom;
            acc(va, rv[17], rv[16], 1'b0, 1'b0);
            dv = dacr[2 * dom +: 2];
            ap = qperm[2 * va[11:10] +: 2];
            code = 4'h0;
            if (dv == DOM_NONE || dv == DOM_RSVD) code = FC_DOM_PAGE;
            else if (dv == DOM_CLIENT && !perm_ok(ap, rv[0], rv[1], rv[16], rv[17]))
                code = FC_PERM_PAGE;
            if (code == 4'h0) begin
                chk(32'({mem_req, data_abort}), 32'h2);
                chk(mem_addr, {ppn, va[11:0]});
                chk(32'({mem_cacheable, mem_bufferable}), 32'(cb));
            end else abort_is({24'h0, dom, code}, va);
        end
        // Large page under a manager domain
        l2_type = L2_LARGE;
        wr(CP_DOMAIN, 32'hFFFF_FFFF);
        acc(32'h1234_5678, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(mem_addr, {ppn[19:4], 16'h5678});
        // Alignment beats a no-access domain; byte and fetch never align-fault
        wr(CP_CTRL, 32'h0000_0003);
        wr(CP_DOMAIN, ZERO_WORD);
        acc(32'h0000_1002, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(CP_STATUS, got);
        chk(got & 32'h0000_000F, 32'(FC_ALIGN));
        acc(32'h0000_2003, 1'b0, 1'b0, 1'b1, 1'b0);
        abort_is({24'h0, dom, FC_DOM_PAGE}, 32'h0000_2003);
        acc(32'h0000_3001, 1'b0, 1'b0, 1'b0, 1'b1);
        chk(32'({prefetch_abort_tag, data_abort}), 32'h2);
        rd(CP_STATUS, got);
        chk(got, {24'h0, dom, FC_DOM_PAGE});
        rd(CP_FADDR, got);
        chk(got, 32'h0000_2003);
        // Invalid entry outranks the domain fault
        l2_type = DESC_INVALID;
        acc(32'h0000_4000, 1'b0, 1'b0, 1'b0, 1'b0);
        abort_is({24'h0, dom, FC_XL_PAGE}, 32'h0000_4000);
        // Fast bus shows the translated address of an abort, with no cycle
        l2_type = L2_SMALL;
        wr(CP_CTRL, 32'h4000_0001);
        acc(32'h0000_7124, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(32'({mem_req, data_abort}), 32'h1);
        chk(mem_addr, {ppn, 12'h124});
        // Table fetch bus errors outrank the domain fault
        l2_err = 1'b1;
        acc(32'h0000_8000, 1'b0, 1'b0, 1'b0, 1'b0);
        abort_is({24'h0, dom, FC_L2_BUS}, 32'h0000_8000);
        l1_err = 1'b1;
        acc(32'h0000_9000, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(CP_STATUS, got);
        chk(got & 32'h0000_000F, 32'(FC_L1_BUS));
        {l1_err, l2_err} = 2'b00;
        // Untranslated: bytes pass flat, an unaligned word still faults
        wr(CP_CTRL, 32'h0000_0002);
        acc(32'h0000_6003, 1'b0, 1'b1, 1'b1, 1'b0);
        chk(32'({mem_req, data_abort}), 32'h2);
        chk(mem_addr, 32'h0000_6003);
        acc(32'h0000_6002, 1'b1, 1'b1, 1'b0, 1'b0);
        chk(32'({mem_req, data_abort}), 32'h1);
        rd(CP_STATUS, got);
        chk(got & 32'h0000_000F, 32'(FC_ALIGN));
        // Bus errors: a linefetch records its line start, others the failing word
        for (int k = 0; k < 2; k++) begin
            @(negedge sys_clk) {bus_err_valid, bus_err_linefetch, bus_err_page} = {1'b1, k == 0, 1'b1};
            {bus_err_domain, bus_err_addr, line_start_addr} = {4'h9, 32'h0000_5008, 32'h0000_5000};
            @(negedge sys_clk) bus_err_valid = 0;
            code = k ? FC_BUS_PAGE : FC_LF_PAGE;
            va = k ? 32'h0000_5008 : 32'h0000_5000;
            abort_is({24'h0, 4'h9, code}, va);
        end
        // Reset in mid-run clears control and records
        @(negedge sys_clk) rst_n = 0;
        @(negedge sys_clk) rst_n = 1;
        rd(CP_CTRL, got);
        chk(got, CTRL_RST);
        rd(CP_STATUS, got);
        chk(got, ZERO_WORD);
        final_report;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #(20000 * 5);
        miscompares++;
        final_report;
    end
endmodule : mfp_access_check_tb

// ---- bench/mfp_table_model.sv ----
`timescale 1ns/10ps
module mfp_table_model
    import mfp_pkg::*;
(
    input wire logic [3:0] dom,
    input wire logic [1:0] l2_type,
    input wire logic [19:0] ppn,
    input wire logic [7:0] qperm,
    input wire logic [1:0] cb,
    output logic [31:0] l1_desc,
    output logic [31:0] l2_desc
);
    // ------------------------------------------------------------
    // Table entries seen by the walk
    // ------------------------------------------------------------
    // Page pointer with domain; bit 4 kept set for compatibility
    assign l1_desc = {22'h00_0001, 1'b0, dom, 1'b1, 2'b00, L1_PAGE};
    // Large entries stored sixteen-fold, so bits 15:12 must stay clear
    assign l2_desc = {ppn[19:4], (l2_type == L2_LARGE) ? 4'h0 : ppn[3:0],
                      qperm, cb, l2_type};
endmodule : mfp_table_model

// ---- include/mfp_pkg.sv ----
package mfp_pkg;
    // ------------------------------------------------------------
    // Coprocessor register numbers
    // ------------------------------------------------------------
    localparam logic [3:0] CP_CTRL = 4'h1;
    localparam logic [3:0] CP_DOMAIN = 4'h3;
    localparam logic [3:0] CP_STATUS = 4'h5;
    localparam logic [3:0] CP_FADDR = 4'h6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DOMAIN_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // ------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------
    localparam int CTRL_MMU_BIT = 0;
    localparam int CTRL_ALIGN_BIT = 1;
    localparam int CTRL_SYS_BIT = 8;
    localparam int CTRL_ROM_BIT = 9;
    localparam int CTRL_FAST_BIT = 30;
    // ------------------------------------------------------------
    // Descriptor fields and encodings
    // ------------------------------------------------------------
    localparam int DESC_B_BIT = 2;
    localparam int DESC_C_BIT = 3;
    localparam int L1_DOM_LSB = 5;
    localparam int SEC_AP_LSB = 10;
    localparam int SUBP_AP_LSB = 4;
    localparam int SEC_BASE_LSB = 20;
    localparam int SMALL_BASE_LSB = 12;
    localparam int LARGE_BASE_LSB = 16;
    localparam int SMALL_QTR_LSB = 10;
    localparam int LARGE_QTR_LSB = 14;
    localparam int FSR_DOM_LSB = 4;
    localparam int DOM_W = 4;
    localparam int FC_W = 4;
    localparam logic [1:0] DESC_INVALID = 2'h0;
    localparam logic [1:0] L1_PAGE = 2'h1;
    localparam logic [1:0] L1_SECTION = 2'h2;
    localparam logic [1:0] L2_LARGE = 2'h1;
    localparam logic [1:0] L2_SMALL = 2'h2;
    localparam logic [1:0] DOM_NONE = 2'h0;
    localparam logic [1:0] DOM_CLIENT = 2'h1;
    localparam logic [1:0] DOM_RSVD = 2'h2;
    localparam logic [1:0] DOM_MGR = 2'h3;
    localparam logic [1:0] PERM_PROT = 2'h0;
    localparam logic [1:0] PERM_SUP = 2'h1;
    localparam logic [1:0] PERM_UREAD = 2'h2;
    localparam logic [1:0] PERM_FULL = 2'h3;
    // ------------------------------------------------------------
    // Fault codes, highest priority first
    // ------------------------------------------------------------
    localparam logic [3:0] FC_ALIGN = 4'h1;
    localparam logic [3:0] FC_L1_BUS = 4'hC;
    localparam logic [3:0] FC_L2_BUS = 4'hE;
    localparam logic [3:0] FC_XL_SEC = 4'h5;
    localparam logic [3:0] FC_XL_PAGE = 4'h7;
    localparam logic [3:0] FC_DOM_SEC = 4'h9;
    localparam logic [3:0] FC_DOM_PAGE = 4'hB;
    localparam logic [3:0] FC_PERM_SEC = 4'hD;
    localparam logic [3:0] FC_PERM_PAGE = 4'hF;
    localparam logic [3:0] FC_LF_SEC = 4'h4;
    localparam logic [3:0] FC_LF_PAGE = 4'h6;
    localparam logic [3:0] FC_BUS_SEC = 4'h8;
    localparam logic [3:0] FC_BUS_PAGE = 4'hA;

    // Keep the descriptor bits above lsb, the virtual bits below it
    function automatic logic [31:0] mfp_merge(input logic [31:0] base,
                                              input logic [31:0] va,
                                              input int lsb);
        logic [31:0] lo_mask;
        lo_mask = 32'hFFFF_FFFF >> (32 - lsb);
        return (base & ~lo_mask) | (va & lo_mask);
    endfunction : mfp_merge
endpackage : mfp_pkg

// ---- rtl/mfp_access_check.sv ----
`timescale 1ns/10ps
module mfp_access_check
    import mfp_pkg::*;
(
    input logic sys_clk,
    input logic rst_n,
    // Coprocessor register port
    input logic cp_wr,
    input logic cp_rd,
    input logic [3:0] cp_sel,
    input logic [31:0] cp_wdata,
    output logic [31:0] cp_rdata,
    // Access from the core, with its walk results
    input logic acc_valid,
    input logic [31:0] acc_vaddr,
    input logic acc_write,
    input logic acc_user,
    input logic acc_byte,
    input logic acc_instr,
    input logic [31:0] l1_desc,
    input logic l1_bus_err,
    input logic [31:0] l2_desc,
    input logic l2_bus_err,
    // Bus errors on data traffic already under way
    input logic bus_err_valid,
    input logic bus_err_linefetch,
    input logic bus_err_page,
    input logic [3:0] bus_err_domain,
    input logic [31:0] bus_err_addr,
    input logic [31:0] line_start_addr,
    // Memory side
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic mem_cacheable,
    output logic mem_bufferable,
    output logic data_abort,
    output logic prefetch_abort_tag
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] dom;
        logic [31:0] rdata;
        logic req;
        logic [31:0] addr;
        logic cach;
        logic bufw;
        logic dabt;
        logic ptag;
    } mfp_top_t;

    mfp_top_t st_q;
    mfp_top_t st_d;

    logic mmu_on;
    logic align_on;
    logic fast_on;
    logic align_hit;
    logic [1:0] l1_type;
    logic [1:0] l2_type;
    logic is_sec;
    logic is_page;
    logic is_large;
    logic is_small;
    logic [3:0] dom_num;
    logic [1:0] dom_val;
    logic [1:0] qtr;
    logic [1:0] cur_ap;
    logic dom_fault;
    logic perm_fault;
    logic acc_fault;
    logic [3:0] acc_code;
    logic [31:0] pa;
    logic use_c;
    logic use_b;
    logic data_fault;
    logic rec_en;
    logic [3:0] rec_code;
    logic [3:0] rec_dom;
    logic [31:0] rec_addr;
    logic [31:0] fsr_w;
    logic [31:0] far_w;

    // ------------------------------------------------------------
    // Descriptor decode
    // ------------------------------------------------------------
    // Control bits steer every check below
    always_comb begin
        mmu_on = st_q.ctrl[CTRL_MMU_BIT];
        align_on = st_q.ctrl[CTRL_ALIGN_BIT];
        fast_on = st_q.ctrl[CTRL_FAST_BIT];
    end

    // Alignment does not depend on translation being on
    always_comb begin
        align_hit = align_on && !acc_instr && !acc_byte &&
                    (acc_vaddr[1:0] != DESC_INVALID);
    end

    // Descriptor types
    always_comb begin
        l1_type = l1_desc[1:0];
        l2_type = l2_desc[1:0];
        is_sec = (l1_type == L1_SECTION);
        is_page = (l1_type == L1_PAGE);
        is_large = (l2_type == L2_LARGE);
        is_small = (l2_type == L2_SMALL);
    end

    // Domain field chosen by the first-level domain number
    always_comb begin
        dom_num = l1_desc[L1_DOM_LSB +: DOM_W];
        dom_val = st_q.dom[2*dom_num +: 2];
    end

    // Quarter of the page picks one of four sub-page fields
    always_comb begin
        qtr = is_large ? acc_vaddr[LARGE_QTR_LSB +: 2]
                       : acc_vaddr[SMALL_QTR_LSB +: 2];
        if (is_sec) begin
            cur_ap = l1_desc[SEC_AP_LSB +: 2];
        end else begin
            cur_ap = l2_desc[SUBP_AP_LSB + 2*qtr +: 2];
        end
    end

    mfp_perm_check u_perm (
        .dom_val(dom_val),
        .ap(cur_ap),
        .sys_prot(st_q.ctrl[CTRL_SYS_BIT]),
        .rom_prot(st_q.ctrl[CTRL_ROM_BIT]),
        .user(acc_user),
        .write(acc_write),
        .dom_fault(dom_fault),
        .perm_fault(perm_fault)
    );

    // ------------------------------------------------------------
    // Fault priority
    // ------------------------------------------------------------
    // First hit wins; later checks are never consulted
    always_comb begin
        acc_fault = 1'b1;
        acc_code = FC_ALIGN;
        if (align_hit) begin
            acc_code = FC_ALIGN;
        end else if (!mmu_on) begin
            acc_fault = 1'b0;
        end else if (l1_bus_err) begin
            acc_code = FC_L1_BUS;
        end else if (!is_sec && !is_page) begin
            acc_code = FC_XL_SEC;
        end else if (is_page && l2_bus_err) begin
            acc_code = FC_L2_BUS;
        end else if (is_page && !is_large && !is_small) begin
            acc_code = FC_XL_PAGE;
        end else if (dom_fault) begin
            acc_code = is_sec ? FC_DOM_SEC : FC_DOM_PAGE;
        end else if (perm_fault) begin
            acc_code = is_sec ? FC_PERM_SEC : FC_PERM_PAGE;
        end else begin
            acc_fault = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Physical address and attributes
    // ------------------------------------------------------------
    // Flat mapping when translation is off
    always_comb begin
        pa = acc_vaddr;
        use_c = 1'b0;
        use_b = 1'b0;
        if (mmu_on && is_sec) begin
            pa = mfp_merge(l1_desc, acc_vaddr, SEC_BASE_LSB);
            use_c = l1_desc[DESC_C_BIT];
            use_b = l1_desc[DESC_B_BIT];
        end else if (mmu_on && is_page) begin
            if (is_large) begin
                pa = mfp_merge(l2_desc, acc_vaddr, LARGE_BASE_LSB);
            end else begin
                pa = mfp_merge(l2_desc, acc_vaddr, SMALL_BASE_LSB);
            end
            use_c = l2_desc[DESC_C_BIT];
            use_b = l2_desc[DESC_B_BIT];
        end
    end

    // ------------------------------------------------------------
    // Fault recording
    // ------------------------------------------------------------
    // A data access fault outranks any bus error arriving alongside it; a prefetch fault is not recorded
    always_comb begin
        data_fault = acc_valid && !acc_instr && acc_fault;
        rec_en = data_fault || bus_err_valid;
        rec_code = acc_code;
        rec_dom = dom_num;
        rec_addr = acc_vaddr;
        if (!data_fault) begin
            rec_dom = bus_err_domain;
            rec_addr = bus_err_addr;
            if (bus_err_linefetch) begin
                rec_code = bus_err_page ? FC_LF_PAGE : FC_LF_SEC;
                rec_addr = line_start_addr;
            end else begin
                rec_code = bus_err_page ? FC_BUS_PAGE : FC_BUS_SEC;
            end
        end
    end

    mfp_fault_record u_rec (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rec_en(rec_en),
        .rec_code(rec_code),
        .rec_dom(rec_dom),
        .rec_addr(rec_addr),
        .status(fsr_w),
        .fault_addr(far_w)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Register port, then the access outcome for the next cycle
    always_comb begin
        st_d = st_q;
        if (cp_wr && cp_sel == CP_CTRL) begin
            st_d.ctrl = cp_wdata;
        end
        if (cp_wr && cp_sel == CP_DOMAIN) begin
            st_d.dom = cp_wdata;
        end
        if (cp_rd) begin
            case (cp_sel)
                CP_CTRL: st_d.rdata = st_q.ctrl;
                CP_DOMAIN: st_d.rdata = st_q.dom;
                CP_STATUS: st_d.rdata = fsr_w;
                CP_FADDR: st_d.rdata = far_w;
                default: st_d.rdata = ZERO_WORD;
            endcase
        end
        // A fault never lets the memory cycle start
        st_d.req = acc_valid && !acc_fault;
        st_d.cach = acc_valid && !acc_fault && use_c;
        st_d.bufw = acc_valid && !acc_fault && use_b;
        // Fast bus leaks the translated address only, no cycle
        if (acc_valid && (!acc_fault || fast_on)) begin
            st_d.addr = pa;
        end
        st_d.dabt = data_fault || bus_err_valid;
        // Prefetch faults travel with the instruction as a tag
        st_d.ptag = acc_valid && acc_instr && acc_fault;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q.ctrl <= CTRL_RST;
            st_q.dom <= DOMAIN_RST;
            st_q.rdata <= ZERO_WORD;
            st_q.req <= 1'b0;
            st_q.addr <= ZERO_WORD;
            st_q.cach <= 1'b0;
            st_q.bufw <= 1'b0;
            st_q.dabt <= 1'b0;
            st_q.ptag <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state flops
    assign cp_rdata = st_q.rdata;
    assign mem_req = st_q.req;
    assign mem_addr = st_q.addr;
    assign mem_cacheable = st_q.cach;
    assign mem_bufferable = st_q.bufw;
    assign data_abort = st_q.dabt;
    assign prefetch_abort_tag = st_q.ptag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking mfp_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_NO_CYCLE_ON_ABORT: assert property (
        (acc_valid && acc_fault) |=> !mem_req && !mem_cacheable)
        else $error("memory cycle started on a faulting access");

    AST_FAST_NO_CYCLE: assert property (
        (acc_valid && acc_fault && fast_on) |=> !mem_req
            && (mem_addr == $past(pa)))
        else $error("fast bus abort ran a cycle or lost the address");

    AST_SUP_ONLY: assert property (
        (dom_val == DOM_CLIENT && cur_ap == PERM_SUP) |-> (perm_fault == acc_user))
        else $error("supervisor-only code decided wrongly");

    AST_USER_READ: assert property (
        (dom_val == DOM_CLIENT && cur_ap == PERM_UREAD)
            |-> (perm_fault == (acc_user && acc_write)))
        else $error("user read-only code decided wrongly");

    AST_FULL_ACCESS: assert property (
        (cur_ap == PERM_FULL) |-> !perm_fault)
        else $error("full access code raised a permission fault");

    AST_MANAGER: assert property (
        (dom_val == DOM_MGR) |-> !perm_fault && !dom_fault)
        else $error("manager domain was checked");

    AST_NO_ACCESS_DOM: assert property (
        (dom_val == DOM_NONE || dom_val == DOM_RSVD) |-> dom_fault)
        else $error("no-access domain did not fault");

    AST_ALIGN_FIRST: assert property (
        (acc_valid && align_hit) |=> data_abort
            && (fsr_w[FC_W-1:0] == FC_ALIGN) && (far_w == $past(acc_vaddr)))
        else $error("alignment fault not reported first");

    AST_NO_ALIGN_BYTE: assert property (
        (acc_valid && acc_byte && !mmu_on && !bus_err_valid)
            |=> !data_abort && mem_req)
        else $error("byte access raised an alignment fault");

    AST_PAGE_INVALID: assert property (
        (acc_valid && !acc_instr && mmu_on && !align_hit && !l1_bus_err
            && is_page && !l2_bus_err && l2_type == DESC_INVALID)
            |=> data_abort && (fsr_w[FC_W-1:0] == FC_XL_PAGE))
        else $error("invalid second-level entry not a page fault");

    AST_SMALL_PA: assert property (
        (acc_valid && !acc_fault && mmu_on && is_page && is_small)
            |=> mem_addr[31:12] == $past(l2_desc[31:12])
                && mem_addr[11:0] == $past(acc_vaddr[11:0]))
        else $error("small page address formed wrongly");

    AST_PREFETCH_KEEP: assert property (
        (acc_valid && acc_instr && !bus_err_valid)
            |=> $stable(fsr_w) && $stable(far_w))
        else $error("prefetch abort touched fault records");

    AST_LINEFETCH_ADDR: assert property (
        (bus_err_valid && bus_err_linefetch && !data_fault)
            |=> far_w == $past(line_start_addr))
        else $error("linefetch error stored the wrong address");
endmodule : mfp_access_check

// ---- rtl/mfp_fault_record.sv ----
`timescale 1ns/10ps
module mfp_fault_record
    import mfp_pkg::*;
(
    input logic sys_clk,
    input logic rst_n,
    input logic rec_en,
    input logic [3:0] rec_code,
    input logic [3:0] rec_dom,
    input logic [31:0] rec_addr,
    output logic [31:0] status,
    output logic [31:0] fault_addr
);
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] faddr;
    } mfp_rec_t;

    mfp_rec_t st_q;
    mfp_rec_t st_d;

    // Capture status and address together on a data abort
    always_comb begin
        st_d = st_q;
        if (rec_en) begin
            st_d.status = ZERO_WORD;
            st_d.status[FSR_DOM_LSB +: DOM_W] = rec_dom;
            st_d.status[FC_W-1:0] = rec_code;
            st_d.faddr = rec_addr;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign status = st_q.status;
    assign fault_addr = st_q.faddr;

    AST_FAR_LATCH: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rec_en |=> (fault_addr == $past(rec_addr))
                   && (status[FC_W-1:0] == $past(rec_code)))
        else $error("fault record missed a data abort");
endmodule : mfp_fault_record

// ---- rtl/mfp_perm_check.sv ----
`timescale 1ns/10ps
module mfp_perm_check
    import mfp_pkg::*;
(
    input logic [1:0] dom_val,
    input logic [1:0] ap,
    input logic sys_prot,
    input logic rom_prot,
    input logic user,
    input logic write,
    output logic dom_fault,
    output logic perm_fault
);
    // ------------------------------------------------------------
    // Permission table
    // ------------------------------------------------------------
    function automatic logic perm_ok(input logic [1:0] code, input logic s,
                                     input logic r, input logic u,
                                     input logic w);
        logic ok;
        ok = 1'b0;
        case (code)
            PERM_PROT: begin
                // Both protect bits set is reserved and denied
                if (s && !r) begin
                    ok = !u && !w;
                end else if (r && !s) begin
                    ok = !w;
                end
            end
            PERM_SUP: ok = !u;
            PERM_UREAD: ok = !(u && w);
            PERM_FULL: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : perm_ok

    // Domain gate first; only client domains see the permission bits
    always_comb begin
        dom_fault = (dom_val == DOM_NONE) || (dom_val == DOM_RSVD);
        perm_fault = (dom_val == DOM_CLIENT) &&
                     !perm_ok(ap, sys_prot, rom_prot, user, write);
    end
endmodule : mfp_perm_check
